// ===== hw/tmw_timer.sv
// 8-bit timer/counter with waveform generator behind an APB slave.
// Assumes APB master on pclk; compare pin drives an external load via port logic.
// Operation
// - Mode 1 counts up then down, continuously
// - Dual-slope code 10: clear up, set down
// - Dual-slope code 11: set up, clear down
// - Code 00 disconnects generator from pin
// - Counter holds maximum one tick, then reverses
// - Dual-slope overflow flag sets at zero
// - Dual-slope period spans 510 ticks
// - Top is 0xFF, or compare in CLEAR_ON_COMPARE_MODE
// - Compare buffered until top in PWM
// - Compare zero/maximum gives constant level (code gives a one-tick pulse each period in fast PWM when compare is zero)
// - Level at maximum equals up-match result (code gives down-match level when compare is maximum)
// - Missed up-match still changes output
// - Compare equals top: act at top
// - Fast PWM: 10 clear/set, 11 inverse
// - Non-PWM: 01 toggle, 10 clear, 11 set
// - Force strobe applies action in non-PWM
// - Force sets no flag, no clear
// - Force strobe reads back zero
// - Nonzero output mode overrides port function, except code 01 in PWM modes
// - Clock select stops, passes, or prescales
// - Timer tick is a clock enable
// - Output mode change acts at next match
// - Counter write blocks next tick's match
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module tmw_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        port_level,
  output logic             compare_output_pin,
  output logic             pin_override,
  output logic             overflow_flag,
  output logic             compare_flag
);
  import tmw_pkg::*;

  tmw_state_t st;
  tmw_state_t next_st;
  tmw_mode_t  mode;
  tmw_cs_t    cs;
  logic [1:0] com;
  logic       is_pwm;
  logic       tick;
  logic [7:0] top;
  logic       match;
  logic       wr;
  logic       rd;
  logic       mapped;
  logic [7:0] cmp_eff;

  // Field decode from control register
  assign mode   = tmw_mode_t'({st.control[BIT_WGM1], st.control[BIT_WGM0]});
  assign cs     = tmw_cs_t'(st.control[BIT_CS_HI:0]);
  assign com    = {st.control[BIT_COM1], st.control[BIT_COM0]};
  assign is_pwm = (mode == TMW_PHASE) || (mode == TMW_FAST);
  assign cmp_eff = st.compare_buf;
  assign top    = (mode == TMW_CTC) ? cmp_eff : CNT_MAX;
  assign match  = (st.counter == cmp_eff) && !st.block_match;

  // APB decode; zero wait states
  assign wr     = psel && penable && pwrite;
  assign rd     = psel && !penable && !pwrite;
  assign mapped = (paddr == ADDR_CONTROL) || (paddr == ADDR_COUNTER) ||
                  (paddr == ADDR_COMPARE) || (paddr == ADDR_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = st.prdata;

  // Outputs
  assign pin_override       = (com != 2'b00) && !(is_pwm && com == 2'b01);
  assign compare_output_pin = pin_override ? st.pin_level : port_level;
  assign overflow_flag      = st.overflow_flag;
  assign compare_flag       = st.compare_flag;

  // Tick generation from prescaler
  always_comb begin
    case (cs)
      TMW_CS_STOP: tick = 1'b0;
      TMW_CS_1:    tick = 1'b1;
      TMW_CS_8:    tick = (st.prescaler & PRE_M8) == PRE_M8;
      TMW_CS_32:   tick = (st.prescaler & PRE_M32) == PRE_M32;
      TMW_CS_64:   tick = (st.prescaler & PRE_M64) == PRE_M64;
      TMW_CS_128:  tick = (st.prescaler & PRE_M128) == PRE_M128;
      TMW_CS_256:  tick = (st.prescaler & PRE_M256) == PRE_M256;
      TMW_CS_1024: tick = (st.prescaler & PRE_M1024) == PRE_M1024;
      default:     tick = 1'b0;
    endcase
  end

  // Next-state logic: counter, waveform, flags, registers
  always_comb begin
    next_st = st;
    next_st.prescaler = st.prescaler + PRE_ONE;
    // Write one clears the flags; a hardware set below in the same cycle wins
    if (wr && paddr == ADDR_STATUS) begin
      if (pwdata[BIT_OVF])
        next_st.overflow_flag = 1'b0;
      if (pwdata[BIT_CMP])
        next_st.compare_flag = 1'b0;
    end
    if (tick) begin
      next_st.block_match = 1'b0;
      case (mode)
        TMW_PHASE: begin
          // 0..FF..0, FF held one tick, 510-tick period
          if (st.dir == TMW_UP) begin
            if (st.counter == CNT_MAX) begin
              next_st.dir     = TMW_DOWN;
              next_st.counter = st.counter - CNT_ONE;
            end else begin
              next_st.counter = st.counter + CNT_ONE;
            end
          end else begin
            if (st.counter == CNT_BOTTOM) begin
              next_st.dir     = TMW_UP;
              next_st.counter = st.counter + CNT_ONE;
            end else begin
              next_st.counter = st.counter - CNT_ONE;
            end
          end
          if (st.counter == CNT_ONE && st.dir == TMW_DOWN)
            next_st.overflow_flag = 1'b1;
          if (match)
            next_st.compare_flag = 1'b1;
          if (com[1]) begin
            if (st.counter == CNT_MAX) begin
              // Level at top equals up-match result; compare maximum holds down-match level
              next_st.pin_level = (cmp_eff == CNT_MAX) ? ~com[0] : com[0];
            end else if (st.counter == CNT_BOTTOM) begin
              // Down-match level at bottom; compare zero holds up-match level
              next_st.pin_level = (cmp_eff == CNT_BOTTOM) ? com[0] : ~com[0];
            end else if (match) begin
              next_st.pin_level = (st.dir == TMW_UP) ? com[0] : ~com[0];
            end
          end
          if (st.counter == CNT_MAX)
            next_st.compare_buf = st.compare;
        end
        TMW_FAST: begin
          if (st.counter == CNT_MAX) begin
            next_st.counter       = CNT_BOTTOM;
            next_st.overflow_flag = 1'b1;
            next_st.compare_buf   = st.compare;
            if (com[1])
              next_st.pin_level = ~com[0];
          end else begin
            next_st.counter = st.counter + CNT_ONE;
          end
          if (match)
            next_st.compare_flag = 1'b1;
          if (com[1] && match && cmp_eff != CNT_MAX)
            next_st.pin_level = com[0];
        end
        default: begin
          // Normal and CLEAR_ON_COMPARE_MODE count up to top
          if (st.counter == top && mode == TMW_CTC) begin
            next_st.counter = CNT_BOTTOM;
          end else begin
            next_st.counter = st.counter + CNT_ONE;
          end
          if (st.counter == CNT_MAX)
            next_st.overflow_flag = 1'b1;
          if (match) begin
            next_st.compare_flag = 1'b1;
            case (com)
              2'b01:   next_st.pin_level = ~st.pin_level;
              2'b10:   next_st.pin_level = 1'b0;
              2'b11:   next_st.pin_level = 1'b1;
              default: next_st.pin_level = st.pin_level;
            endcase
          end
        end
      endcase
    end
    // Non-PWM compare writes act at once
    if (!is_pwm)
      next_st.compare_buf = st.compare;
    // Register writes
    if (wr) begin
      case (paddr)
        ADDR_CONTROL: begin
          next_st.control = pwdata[7:0] & ~(8'h01 << BIT_FORCE);
          if (pwdata[BIT_FORCE] &&
              !(pwdata[BIT_WGM0])) begin
            case ({pwdata[BIT_COM1], pwdata[BIT_COM0]})
              2'b01:   next_st.pin_level = ~st.pin_level;
              2'b10:   next_st.pin_level = 1'b0;
              2'b11:   next_st.pin_level = 1'b1;
              default: next_st.pin_level = st.pin_level;
            endcase
          end
        end
        ADDR_COUNTER: begin
          next_st.counter     = pwdata[7:0];
          next_st.block_match = 1'b1;
        end
        ADDR_COMPARE: next_st.compare = pwdata[7:0];
        ADDR_STATUS: ; // Flags cleared before the tick logic
        default: ;
      endcase
    end
    // Read data captured in setup phase
    if (rd) begin
      case (paddr)
        ADDR_CONTROL: next_st.prdata = {24'h000000, st.control};
        ADDR_COUNTER: next_st.prdata = {24'h000000, st.counter};
        ADDR_COMPARE: next_st.prdata = {24'h000000, st.compare};
        ADDR_STATUS:  next_st.prdata = {30'h00000000, st.compare_flag, st.overflow_flag};
        default:      next_st.prdata = 32'h00000000;
      endcase
    end
  end

  // State register with clock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{control: CONTROL_RESET, counter: CNT_BOTTOM, compare: CNT_BOTTOM,
              compare_buf: CNT_BOTTOM, overflow_flag: 1'b0, compare_flag: 1'b0,
              pin_level: 1'b0, block_match: 1'b0, prescaler: PRE_ZERO,
              dir: TMW_UP, prdata: 32'h00000000};
    end else if (clk_en) begin
      st <= next_st;
    end
  end
endmodule : tmw_timer

// ===== hw/tmw_pkg.sv
// Package for the 8-bit timer with waveform generator.
// Assumes a single pclk domain; used by tmw_timer.
package tmw_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COUNTER = 8'h04;
  localparam logic [7:0] ADDR_COMPARE = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  // Control field positions
  localparam int BIT_FORCE  = 7;
  localparam int BIT_WGM0   = 6;
  localparam int BIT_COM1   = 5;
  localparam int BIT_COM0   = 4;
  localparam int BIT_WGM1   = 3;
  localparam int BIT_CS_HI  = 2;
  // Status bit positions
  localparam int BIT_OVF    = 0;
  localparam int BIT_CMP    = 1;
  // Reset values and limits
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CNT_BOTTOM    = 8'h00;
  localparam logic [7:0] CNT_MAX       = 8'hFF;
  localparam logic [7:0] CNT_ONE       = 8'h01;
  localparam logic [9:0] PRE_ZERO      = 10'h000;
  // Prescale masks: tick when low bits of prescaler are all ones
  localparam logic [9:0] PRE_M8    = 10'h007;
  localparam logic [9:0] PRE_M32   = 10'h01F;
  localparam logic [9:0] PRE_M64   = 10'h03F;
  localparam logic [9:0] PRE_M128  = 10'h07F;
  localparam logic [9:0] PRE_M256  = 10'h0FF;
  localparam logic [9:0] PRE_M1024 = 10'h3FF;
  localparam logic [9:0] PRE_ONE   = 10'h001;

  typedef enum logic [1:0] {
    TMW_NORMAL = 2'h0,
    TMW_PHASE  = 2'h1,
    TMW_CTC    = 2'h2,
    TMW_FAST   = 2'h3
  } tmw_mode_t;

  typedef enum logic [2:0] {
    TMW_CS_STOP = 3'h0,
    TMW_CS_1    = 3'h1,
    TMW_CS_8    = 3'h2,
    TMW_CS_32   = 3'h3,
    TMW_CS_64   = 3'h4,
    TMW_CS_128  = 3'h5,
    TMW_CS_256  = 3'h6,
    TMW_CS_1024 = 3'h7
  } tmw_cs_t;

  // Direction of the dual-slope count, one-hot
  typedef enum logic [1:0] {
    TMW_UP   = 2'b01,
    TMW_DOWN = 2'b10
  } tmw_dir_t;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] counter;
    logic [7:0] compare;
    logic [7:0] compare_buf;
    logic       overflow_flag;
    logic       compare_flag;
    logic       pin_level;
    logic       block_match;
    logic [9:0] prescaler;
    tmw_dir_t   dir;
    logic [31:0] prdata;
  } tmw_state_t;
endpackage : tmw_pkg

// ===== verif/tmw_checker.sv
// Checker: bus answers, flag clearing and pin routing of the timer.
// Assumes it is bound to tmw_timer and sees only its ports.
`timescale 1ns/1ps
module tmw_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        port_level,
  input wire logic        compare_output_pin,
  input wire logic        pin_override,
  input wire logic        overflow_flag,
  input wire logic        compare_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Status writes that clear each flag
  logic clr_ovf;
  logic clr_cmp;
  assign clr_ovf = psel && penable && pwrite && clk_en && paddr == 8'h0C && pwdata[0];
  assign clr_cmp = psel && penable && pwrite && clk_en && paddr == 8'h0C && pwdata[1];
  // Bus phases of a read
  sequence setup_s; psel && !penable; endsequence
  sequence rd_s; setup_s ##1 psel && penable && !pwrite; endsequence
  ready_high_a: assert property (psel && penable |-> pready) else $error("no ready");
  bad_addr_a: assert property (psel && penable && paddr > 8'h0C |-> pslverr)
    else $error("no error answer");
  bad_read_a: assert property (rd_s ##0 paddr > 8'h0C |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  force_read_a:
    assert property (rd_s ##0 paddr == 8'h00 |-> !prdata[7]) else $error("strobe reads one");
  port_pass_a:
    assert property (!pin_override |-> compare_output_pin == port_level) else $error("pin lost");
  freeze_a:
    assert property (!clk_en |=> $stable({overflow_flag, compare_flag})) else $error("moved");
  ovf_clear_a: assert property ($fell(overflow_flag) |-> $past(clr_ovf))
    else $error("overflow flag fell alone");
  cmp_clear_a: assert property ($fell(compare_flag) |-> $past(clr_cmp))
    else $error("compare flag fell alone");
endmodule : tmw_checker
bind tmw_timer tmw_checker u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_level(port_level),
  .compare_output_pin(compare_output_pin), .pin_override(pin_override),
  .overflow_flag(overflow_flag), .compare_flag(compare_flag));

// ===== verif/tmw_load.sv
// Load model on the compare pin: measures period and high time.
// Assumes the pin is sampled on pclk; clr empties the rise count.
`timescale 1ns/1ps
module tmw_load (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        level,
  input  wire logic        clr,
  output logic             seen,
  output logic [15:0]      period,
  output logic [15:0]      high,
  output logic [7:0]       edges
);
  logic        prev;
  logic        rise;
  logic [15:0] cnt;
  logic [15:0] hcnt;
  assign rise = level && !prev;
  // Cycle counts between rising edges, reported one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {prev, seen, cnt, hcnt, period, high, edges} <= '0;
    end else begin
      prev  <= level;
      seen  <= rise;
      cnt   <= rise ? 16'h1 : cnt + 16'h1;
      hcnt  <= rise ? 16'h1 : hcnt + {15'h0, level};
      edges <= clr ? 8'h0 : edges + {7'h0, rise};
      if (rise) begin
        period <= cnt;
        high   <= hcnt;
      end
    end
  end
endmodule : tmw_load

// ===== verif/tmw_timer_tb.sv
// Self-checking bench for the timer: bus, forced actions, PWM shapes.
// Assumes tmw_pkg offsets; the load model measures the pin.
`timescale 1ns/1ps
module tmw_timer_tb;
  import tmw_pkg::*;
  logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, port_level = 0, pin, ovr, ovf, cmpf, seen, clr = 1, peek = 0;
  logic [7:0]  paddr = '0, c, edges;
  logic [31:0] pwdata = '0, prdata, rnd = 32'd98940, exp_q[$];
  logic [15:0] period, high;
  logic [1:0]  arm = 0;
  logic [3:0]  fc[4] = '{4'b0111, 4'b1100, 4'b0011, 4'b1010};
  logic [7:0]  pw[4] = '{8'h69, 8'h62, 8'h71, 8'h61};
  logic [7:0]  kc[3] = '{8'h61, 8'h61, 8'h69};
  logic [7:0]  kv[3] = '{8'h00, 8'hFF, 8'hFF};
  int          err_total = 0, total_checks = 0, n, per, hi;
  always #5 pclk = ~pclk;
  tmw_timer dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_level(port_level), .compare_output_pin(pin),
    .pin_override(ovr), .overflow_flag(ovf), .compare_flag(cmpf));
  tmw_load load (.pclk(pclk), .presetn(presetn), .level(pin), .clr(clr), .seen(seen),
    .period(period), .high(high), .edges(edges));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic stop_test;
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    if (!w) exp_q.push_back(e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic look(input logic [31:0] e);
    exp_q.push_back(e);
    peek <= 1'b1;
    @(posedge pclk);
    peek <= 1'b0;
    @(posedge pclk);
  endtask : look
  task automatic meas(input logic [1:0] a, input logic [31:0] e);
    repeat (3) @(posedge seen);
    exp_q.push_back(e);
    arm <= a;
    @(posedge pclk);
    wait (arm == 2'b00);
    @(posedge pclk);
  endtask : meas
  // Compare each observed result with the oldest noted one
  always @(posedge pclk) begin
    if (psel && penable && !pwrite) chk(prdata, exp_q.pop_front());
    if (peek) chk({edges, 22'h0, ovr, pin}, exp_q.pop_front());
    if (arm != 0 && seen) begin
      chk({period, arm[1] ? high : 16'h0}, exp_q.pop_front());
      arm <= 2'b00;
    end
  end
  // Watchdog
  initial begin
    repeat (80000) @(posedge pclk);
    err_total++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_CONTROL, 0, {24'h0, CONTROL_RESET});
    foreach (fc[i]) begin
      apb(1, ADDR_CONTROL, {24'h0, 2'b10, fc[i][2:1], fc[i][3], 3'h0}, 0);
      look({31'h1, fc[i][0]});
    end
    apb(0, ADDR_CONTROL, 0, 32'h18);
    apb(0, ADDR_STATUS, 0, 32'h0);
    apb(0, 8'h10, 0, 32'h0);
    apb(1, ADDR_CONTROL, 0, 0);
    repeat (2) begin
      rnd = lfsr(rnd);
      port_level <= rnd[0];
      @(posedge pclk);
      look({31'h0, rnd[0]});
    end
    foreach (pw[i]) begin
      rnd = lfsr(rnd);
      c = {1'b0, rnd[6:0]} | 8'h01;
      n = (pw[i][2:0] == 3'h2) ? 8 : 1;
      per = (pw[i][3] ? 256 : 510) * n;
      hi = pw[i][4] ? per - 2 * c * n : 2 * c * n;
      apb(1, ADDR_COMPARE, {24'h0, c}, 0);
      apb(1, ADDR_CONTROL, {24'h0, pw[i]}, 0);
      meas(pw[i][3] ? 2'b01 : 2'b10, {per[15:0], pw[i][3] ? 16'h0 : hi[15:0]});
    end
    clk_en <= 1'b0;
    repeat (20) @(posedge pclk);
    clk_en <= 1'b1;
    apb(1, ADDR_CONTROL, 32'h60, 0);
    apb(1, ADDR_STATUS, 32'h3, 0);
    repeat (600) @(posedge pclk);
    apb(0, ADDR_STATUS, 0, 32'h0);
    apb(1, ADDR_CONTROL, 32'h61, 0);
    repeat (520) @(posedge pclk);
    apb(0, ADDR_STATUS, 0, 32'h3);
    foreach (kc[i]) begin
      apb(1, ADDR_COMPARE, {24'h0, kv[i]}, 0);
      apb(1, ADDR_CONTROL, {24'h0, kc[i]}, 0);
      repeat (600) @(posedge pclk);
      clr <= 1'b0;
      repeat (1100) @(posedge pclk);
      look({31'h1, kv[i][0]});
      clr <= 1'b1;
    end
    stop_test();
  end
endmodule : tmw_timer_tb
